// ### logic/codec_cfg_map.svh
// register offsets, field positions and reset values of the pll fraction,
// datapath setup and serial interface control a registers
// assumes byte wide registers addressed on page zero of the control port
`ifndef CODEC_CFG_MAP_SVH
`define CODEC_CFG_MAP_SVH

// register offsets
`define OFS_PAGE_SELECT 8'h00
`define OFS_PLL_FRACTION_HIGH 8'h05
`define OFS_PLL_FRACTION_LOW 8'h06
`define OFS_CODEC_DATAPATH_SETUP 8'h07
`define OFS_SERIAL_INTERFACE_CONTROL_A 8'h08

// reset values
`define RST_PAGE_SELECT 1'h0
`define RST_PLL_FRACTION_HIGH 8'h00
`define RST_PLL_FRACTION_LOW 6'h00
`define RST_CODEC_DATAPATH_SETUP 8'h00
`define RST_SERIAL_INTERFACE_CONTROL_A 8'h00

// pll fraction low register fields
`define FRAC_LOW_MSB 7
`define FRAC_LOW_LSB 2

// datapath setup fields
`define DP_REF_RATE_BIT 7
`define DP_ADC_DUAL_BIT 6
`define DP_DAC_DUAL_BIT 5
`define DP_LEFT_ROUTE_MSB 4
`define DP_LEFT_ROUTE_LSB 3
`define DP_RIGHT_ROUTE_MSB 2
`define DP_RIGHT_ROUTE_LSB 1

// serial interface control a fields
`define SA_BIT_CLK_MASTER_BIT 7
`define SA_WORD_CLK_MASTER_BIT 6
`define SA_OUT_TRISTATE_BIT 5
`define SA_CLK_KEEP_RUN_BIT 4
`define SA_EFFECT_3D_BIT 2
`define SA_MIC_MSB 1
`define SA_MIC_LSB 0

// digital microphone oversampling ratios
`define MIC_OSR_128 8'h80
`define MIC_OSR_64 8'h40
`define MIC_OSR_32 8'h20

`endif

// ### logic/codec_cfg_pkg.sv
// types shared by the codec configuration block and its surroundings
// assumes signed two's complement audio samples
package codec_cfg_pkg;

   // width of one audio sample lane
   localparam int SAMPLE_W = 16;

   // dac lane source selection
   typedef enum logic [1:0] {
      ROUTE_MUTE = 2'b00,
      ROUTE_OWN = 2'b01,
      ROUTE_OTHER = 2'b10,
      ROUTE_MONO = 2'b11
   } route_t;

   // digital microphone mode
   typedef enum logic [1:0] {
      MIC_OFF = 2'b00,
      MIC_OSR128 = 2'b01,
      MIC_OSR64 = 2'b10,
      MIC_OSR32 = 2'b11
   } mic_mode_t;

   // one stereo sample
   typedef struct packed {
      logic signed [SAMPLE_W-1:0] left;
      logic signed [SAMPLE_W-1:0] right;
   } sample_pair_t;

   // output and output enable of one pad
   typedef struct packed {
      logic o;
      logic oe;
   } pad_drive_t;

endpackage

// ### logic/codec_pll_datapath_serial_config.sv
// codec configuration registers: pll fraction, datapath setup and serial
// interface control a, plus the datapath routing and pin control they steer
// assumes a byte wide register port already decoded from the control bus,
// and master clocks generated elsewhere from the pll
`timescale 1ns/1ps
`include "codec_cfg_map.svh"

module codec_pll_datapath_serial_config
   import codec_cfg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire logic cfg_write,
   input wire logic cfg_read,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_rvalid,
   // codec power state
   input wire logic codec_powered_down,
   // alternate pin selection for the serial clocks
   input wire logic bit_clock_on_pin_two,
   input wire logic word_clock_on_pin_one,
   // master clocks from the local divider
   input wire logic master_bit_clock,
   input wire logic master_word_clock,
   // bit clock pad
   input wire logic bit_clock_i,
   output logic bit_clock_o,
   output logic bit_clock_oe,
   // word clock pad
   input wire logic word_clock_i,
   output logic word_clock_o,
   output logic word_clock_oe,
   // alternate pads
   input wire logic general_pin_one_i,
   output logic general_pin_one_o,
   output logic general_pin_one_oe,
   input wire logic general_pin_two_i,
   output logic general_pin_two_o,
   output logic general_pin_two_oe,
   // serial clocks seen by the interface logic
   output logic serial_bit_clock,
   output logic serial_word_clock,
   // serial data output
   input wire logic tx_bit,
   input wire logic tx_valid,
   output logic data_out_o,
   output logic data_out_oe,
   // playback samples
   input wire sample_pair_t play_in,
   input wire logic play_valid,
   output sample_pair_t dac_out,
   output logic dac_valid,
   // configuration to the rest of the codec
   output logic [13:0] pll_fraction,
   output logic pll_fraction_update,
   output logic reference_sample_rate,
   output logic adc_dual_rate,
   output logic dac_dual_rate,
   output logic effect_3d_enable,
   output logic mic_enable,
   output logic [7:0] mic_oversample
);

   // stored register contents
   logic page_one;
   logic [7:0] frac_high;
   logic [5:0] frac_low;
   logic [7:0] datapath_setup;
   logic [7:0] serial_ctrl_a;
   logic next_page_one;
   logic [7:0] next_frac_high;
   logic [5:0] next_frac_low;
   logic [7:0] next_datapath_setup;
   logic [7:0] next_serial_ctrl_a;
   logic [13:0] next_pll_fraction;
   logic next_pll_fraction_update;
   logic [7:0] next_cfg_rdata;
   logic next_cfg_rvalid;

   // decoded fields
   route_t left_route;
   route_t right_route;
   mic_mode_t mic_mode;
   logic bit_clk_master;
   logic word_clk_master;
   logic clocks_run;

   // one lane of the dac routing
   function automatic logic signed [SAMPLE_W-1:0] mix_lane(
      input route_t sel,
      input logic signed [SAMPLE_W-1:0] own,
      input logic signed [SAMPLE_W-1:0] other
   );
      logic signed [SAMPLE_W:0] sum;
      sum = {own[SAMPLE_W-1], own} + {other[SAMPLE_W-1], other};
      unique case (sel)
         ROUTE_MUTE: mix_lane = '0;
         ROUTE_OWN: mix_lane = own;
         ROUTE_OTHER: mix_lane = other;
         ROUTE_MONO: mix_lane = sum[SAMPLE_W:1];
      endcase
   endfunction

   function automatic logic hit(
      input logic [7:0] addr,
      input logic [7:0] ofs,
      input logic pg1
   );
      hit = (addr == ofs) && !pg1;
   endfunction

   // field decode
   assign left_route = route_t'(datapath_setup[`DP_LEFT_ROUTE_MSB:`DP_LEFT_ROUTE_LSB]);
   assign right_route = route_t'(datapath_setup[`DP_RIGHT_ROUTE_MSB:`DP_RIGHT_ROUTE_LSB]);
   assign mic_mode = mic_mode_t'(serial_ctrl_a[`SA_MIC_MSB:`SA_MIC_LSB]);
   assign bit_clk_master = serial_ctrl_a[`SA_BIT_CLK_MASTER_BIT];
   assign word_clk_master = serial_ctrl_a[`SA_WORD_CLK_MASTER_BIT];
   assign clocks_run = !codec_powered_down || serial_ctrl_a[`SA_CLK_KEEP_RUN_BIT];

   // configuration levels straight from the stored registers
   // reference rate select
   assign reference_sample_rate = datapath_setup[`DP_REF_RATE_BIT];
   assign adc_dual_rate = datapath_setup[`DP_ADC_DUAL_BIT];
   assign dac_dual_rate = datapath_setup[`DP_DAC_DUAL_BIT];
   assign effect_3d_enable = serial_ctrl_a[`SA_EFFECT_3D_BIT];

   // register writes, read answers and fraction hand-over
   always_comb begin
      next_page_one = page_one;
      next_frac_high = frac_high;
      next_frac_low = frac_low;
      next_datapath_setup = datapath_setup;
      next_serial_ctrl_a = serial_ctrl_a;
      next_pll_fraction = pll_fraction;
      next_pll_fraction_update = 1'b0;
      next_cfg_rdata = cfg_rdata;
      next_cfg_rvalid = 1'b0;
      if (cfg_write) begin
         if (cfg_addr == `OFS_PAGE_SELECT) begin
            next_page_one = cfg_wdata[0];
         end
         if (hit(cfg_addr, `OFS_PLL_FRACTION_HIGH, page_one)) begin
            next_frac_high = cfg_wdata;
         end
         if (hit(cfg_addr, `OFS_PLL_FRACTION_LOW, page_one)) begin
            next_frac_low = cfg_wdata[`FRAC_LOW_MSB:`FRAC_LOW_LSB];
            next_pll_fraction = {frac_high, cfg_wdata[`FRAC_LOW_MSB:`FRAC_LOW_LSB]};
            next_pll_fraction_update = 1'b1;
         end
         if (hit(cfg_addr, `OFS_CODEC_DATAPATH_SETUP, page_one)) begin
            next_datapath_setup = cfg_wdata;
         end
         if (hit(cfg_addr, `OFS_SERIAL_INTERFACE_CONTROL_A, page_one)) begin
            next_serial_ctrl_a = cfg_wdata;
         end
      end else if (cfg_read) begin
         next_cfg_rvalid = 1'b1;
         next_cfg_rdata = 8'h00;
         if (cfg_addr == `OFS_PAGE_SELECT) begin
            next_cfg_rdata = {7'h00, page_one};
         end else if (hit(cfg_addr, `OFS_PLL_FRACTION_HIGH, page_one)) begin
            next_cfg_rdata = frac_high;
         end else if (hit(cfg_addr, `OFS_PLL_FRACTION_LOW, page_one)) begin
            next_cfg_rdata = {frac_low, 2'h0};
         end else if (hit(cfg_addr, `OFS_CODEC_DATAPATH_SETUP, page_one)) begin
            next_cfg_rdata = datapath_setup;
         end else if (hit(cfg_addr, `OFS_SERIAL_INTERFACE_CONTROL_A, page_one)) begin
            next_cfg_rdata = serial_ctrl_a;
         end
      end
   end

   // register state
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         page_one <= `RST_PAGE_SELECT;
         frac_high <= `RST_PLL_FRACTION_HIGH;
         frac_low <= `RST_PLL_FRACTION_LOW;
         datapath_setup <= `RST_CODEC_DATAPATH_SETUP;
         serial_ctrl_a <= `RST_SERIAL_INTERFACE_CONTROL_A;
         pll_fraction <= 14'h0000;
         pll_fraction_update <= 1'b0;
         cfg_rdata <= 8'h00;
         cfg_rvalid <= 1'b0;
      end else begin
         page_one <= next_page_one;
         frac_high <= next_frac_high;
         frac_low <= next_frac_low;
         datapath_setup <= next_datapath_setup;
         serial_ctrl_a <= next_serial_ctrl_a;
         pll_fraction <= next_pll_fraction;
         pll_fraction_update <= next_pll_fraction_update;
         cfg_rdata <= next_cfg_rdata;
         cfg_rvalid <= next_cfg_rvalid;
      end
   end

   // playback routing
   sample_pair_t next_dac_out;
   logic next_dac_valid;

   // dac lane selection and mono mix
   always_comb begin
      next_dac_out = dac_out;
      next_dac_valid = play_valid;
      if (play_valid) begin
         next_dac_out.left = mix_lane(left_route, play_in.left, play_in.right);
         next_dac_out.right = mix_lane(right_route, play_in.right, play_in.left);
      end
   end

   // playback registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dac_out <= '0;
         dac_valid <= 1'b0;
      end else begin
         dac_out <= next_dac_out;
         dac_valid <= next_dac_valid;
      end
   end

   // microphone decode
   logic next_mic_enable;
   logic [7:0] next_mic_oversample;

   always_comb begin
      next_mic_enable = 1'b1;
      next_mic_oversample = 8'h00;
      unique case (mic_mode)
         MIC_OFF: next_mic_enable = 1'b0;
         MIC_OSR128: next_mic_oversample = `MIC_OSR_128;
         MIC_OSR64: next_mic_oversample = `MIC_OSR_64;
         MIC_OSR32: next_mic_oversample = `MIC_OSR_32;
      endcase
   end

   // microphone registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mic_enable <= 1'b0;
         mic_oversample <= 8'h00;
      end else begin
         mic_enable <= next_mic_enable;
         mic_oversample <= next_mic_oversample;
      end
   end

   // pin drive
   pad_drive_t next_bit_pad;
   pad_drive_t next_word_pad;
   pad_drive_t next_pin_one;
   pad_drive_t next_pin_two;
   pad_drive_t next_data_pad;
   logic next_serial_bit_clock;
   logic next_serial_word_clock;

   // clock direction, alternate pins and data float control
   always_comb begin
      next_bit_pad = '0;
      next_word_pad = '0;
      next_pin_one = '0;
      next_pin_two = '0;
      if (bit_clk_master) begin
         next_bit_pad.o = master_bit_clock && clocks_run;
         next_bit_pad.oe = !bit_clock_on_pin_two;
         next_pin_two.o = master_bit_clock && clocks_run;
         next_pin_two.oe = bit_clock_on_pin_two;
         next_serial_bit_clock = master_bit_clock && clocks_run;
      end else begin
         next_serial_bit_clock = bit_clock_on_pin_two ? general_pin_two_i : bit_clock_i;
      end
      if (word_clk_master) begin
         next_word_pad.o = master_word_clock && clocks_run;
         next_word_pad.oe = !word_clock_on_pin_one;
         next_pin_one.o = master_word_clock && clocks_run;
         next_pin_one.oe = word_clock_on_pin_one;
         next_serial_word_clock = master_word_clock && clocks_run;
      end else begin
         next_serial_word_clock = word_clock_on_pin_one ? general_pin_one_i : word_clock_i;
      end
      next_data_pad.o = tx_valid ? tx_bit : 1'b0;
      next_data_pad.oe = tx_valid || !serial_ctrl_a[`SA_OUT_TRISTATE_BIT];
   end

   // pin registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bit_clock_o <= 1'b0;
         bit_clock_oe <= 1'b0;
         word_clock_o <= 1'b0;
         word_clock_oe <= 1'b0;
         general_pin_one_o <= 1'b0;
         general_pin_one_oe <= 1'b0;
         general_pin_two_o <= 1'b0;
         general_pin_two_oe <= 1'b0;
         data_out_o <= 1'b0;
         data_out_oe <= 1'b1;
         serial_bit_clock <= 1'b0;
         serial_word_clock <= 1'b0;
      end else begin
         bit_clock_o <= next_bit_pad.o;
         bit_clock_oe <= next_bit_pad.oe;
         word_clock_o <= next_word_pad.o;
         word_clock_oe <= next_word_pad.oe;
         general_pin_one_o <= next_pin_one.o;
         general_pin_one_oe <= next_pin_one.oe;
         general_pin_two_o <= next_pin_two.o;
         general_pin_two_oe <= next_pin_two.oe;
         data_out_o <= next_data_pad.o;
         data_out_oe <= next_data_pad.oe;
         serial_bit_clock <= next_serial_bit_clock;
         serial_word_clock <= next_serial_word_clock;
      end
   end

endmodule

// ### verification/host_model.sv
// host processor model driving the register port of the codec block
// assumes requests launch at the falling edge of sys_clk
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic sys_clk,
   // register port
   output logic cfg_write,
   output logic cfg_read,
   output logic [7:0] cfg_addr,
   output logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_rvalid
);
   // idle port at time zero
   initial begin
      cfg_write = 1'b0;
      cfg_read = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
   end
   // one write strobe, then a scrambled bus so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      cfg_write = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge sys_clk);
      cfg_write = 1'b0;
      cfg_addr = ~a;
      cfg_wdata = ~d;
   endtask
   // one read strobe, answer taken a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge sys_clk);
      cfg_read = 1'b1;
      cfg_addr = a;
      @(negedge sys_clk);
      cfg_read = 1'b0;
      cfg_addr = ~a;
      d = cfg_rdata;
      v = cfg_rvalid;
   endtask
   task automatic set_frac(input logic [13:0] v);
      logic [13:0] c;
      c = (v > 14'h270F) ? 14'h270F : v;
      wr(8'h05, c[13:6]);
      wr(8'h06, {c[5:0], 2'b00});
   endtask
endmodule

// ### verification/codec_cfg_asserts.sv
// assertions on the codec configuration block ports
// assumes binding to the top module, one clock domain
`timescale 1ns/1ps
module codec_cfg_asserts (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire logic cfg_write,
   input wire logic cfg_read,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   // pins and settings
   input wire logic codec_powered_down,
   input wire logic tx_valid,
   input wire logic data_out_oe,
   input wire logic bit_clock_oe,
   input wire logic bit_clock_o,
   input wire logic [13:0] pll_fraction,
   input wire logic pll_fraction_update,
   input wire logic reference_sample_rate,
   input wire logic adc_dual_rate,
   input wire logic dac_dual_rate,
   input wire logic mic_enable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic pg, next_pg, rd, fw5, fw6, fw7, fw8;
   logic [7:0] hi, next_hi, sa, next_sa;
   // accepted reads and page zero writes
   assign rd = cfg_read && !cfg_write;
   assign fw5 = cfg_write && !pg && cfg_addr == 8'h05;
   assign fw6 = cfg_write && !pg && cfg_addr == 8'h06;
   assign fw7 = cfg_write && !pg && cfg_addr == 8'h07;
   assign fw8 = cfg_write && !pg && cfg_addr == 8'h08;
   // mirror of page, upper fraction and control a
   always_comb begin
      next_pg = (cfg_write && cfg_addr == 8'h00) ? cfg_wdata[0] : pg;
      next_hi = fw5 ? cfg_wdata : hi;
      next_sa = fw8 ? cfg_wdata : sa;
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pg <= 1'b0;
         hi <= 8'h00;
         sa <= 8'h00;
      end else begin
         pg <= next_pg;
         hi <= next_hi;
         sa <= next_sa;
      end
   end
   AST_FRAC_LOAD: assert property (fw6 |=> pll_fraction_update &&
      pll_fraction == {$past(hi), $past(cfg_wdata[7:2])}) else $error("fraction not loaded");
   AST_FRAC_HOLD: assert property (!fw6 |=> $stable(pll_fraction) && !pll_fraction_update)
      else $error("fraction moved without lower write");
   AST_RD_LOW: assert property (rd && !pg && cfg_addr == 8'h06 |=> cfg_rdata[1:0] == 2'b00)
      else $error("reserved fraction bits not zero");
   AST_PAGE_RD: assert property (rd && pg && cfg_addr inside {[8'h05:8'h08]}
      |=> cfg_rdata == 8'h00) else $error("register answered on page one");
   AST_REF: assert property (fw7 |=> reference_sample_rate == $past(cfg_wdata[7]))
      else $error("reference rate differs from write");
   AST_DUAL: assert property (fw7 |=> {adc_dual_rate, dac_dual_rate} == $past(cfg_wdata[6:5]))
      else $error("dual rate differs from write");
   AST_MIC: assert property (fw8 |=> ##1 mic_enable == ($past(cfg_wdata[1:0], 2) != 2'b00))
      else $error("microphone enable wrong");
   AST_BCLK_IN: assert property (!sa[7] |=> !bit_clock_oe)
      else $error("bit clock driven as follower");
   AST_CLK_STOP: assert property (sa[7] && !sa[4] && codec_powered_down |=> !bit_clock_o)
      else $error("bit clock runs while powered down");
   AST_DOUT_FLOAT: assert property (sa[5] && !tx_valid |=> !data_out_oe)
      else $error("data output driven without data");
endmodule
bind codec_pll_datapath_serial_config codec_cfg_asserts chk (.sys_clk, .reset, .cfg_write,
   .cfg_read, .cfg_addr, .cfg_wdata, .cfg_rdata, .codec_powered_down, .tx_valid, .data_out_oe,
   .bit_clock_oe, .bit_clock_o, .pll_fraction, .pll_fraction_update, .reference_sample_rate,
   .adc_dual_rate, .dac_dual_rate, .mic_enable);

// ### verification/tb.sv
// self-checking bench for the codec configuration block
// assumes the host model drives the register port, all else driven here
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb
   import codec_cfg_pkg::*;
;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic sys_clk = 1'b0, reset = 1'b1, codec_powered_down = 1'b0, bit_clock_on_pin_two = 1'b0;
   logic word_clock_on_pin_one = 1'b0, master_bit_clock = 1'b1, master_word_clock = 1'b1;
   logic bit_clock_i = 1'b0, word_clock_i = 1'b0, general_pin_one_i = 1'b0;
   logic general_pin_two_i = 1'b0, tx_bit = 1'b0, tx_valid = 1'b0, play_valid = 1'b0;
   logic cfg_write, cfg_read, cfg_rvalid, bit_clock_o, bit_clock_oe, word_clock_o, word_clock_oe;
   logic general_pin_one_o, general_pin_one_oe, general_pin_two_o, general_pin_two_oe;
   logic serial_bit_clock, serial_word_clock, data_out_o, data_out_oe, dac_valid, mic_enable;
   logic pll_fraction_update, reference_sample_rate, adc_dual_rate, dac_dual_rate;
   logic effect_3d_enable;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, mic_oversample;
   logic [13:0] pll_fraction;
   sample_pair_t play_in = '0;
   sample_pair_t dac_out;
   // block under test and host
   codec_pll_datapath_serial_config dut (.sys_clk, .reset, .cfg_write, .cfg_read, .cfg_addr,
      .cfg_wdata, .cfg_rdata, .cfg_rvalid, .codec_powered_down, .bit_clock_on_pin_two,
      .word_clock_on_pin_one, .master_bit_clock, .master_word_clock, .bit_clock_i,
      .bit_clock_o, .bit_clock_oe, .word_clock_i, .word_clock_o, .word_clock_oe,
      .general_pin_one_i, .general_pin_one_o, .general_pin_one_oe, .general_pin_two_i,
      .general_pin_two_o, .general_pin_two_oe, .serial_bit_clock, .serial_word_clock, .tx_bit,
      .tx_valid, .data_out_o, .data_out_oe, .play_in, .play_valid, .dac_out, .dac_valid,
      .pll_fraction, .pll_fraction_update, .reference_sample_rate, .adc_dual_rate,
      .dac_dual_rate, .effect_3d_enable, .mic_enable, .mic_oversample);
   host_model host (.sys_clk, .cfg_write, .cfg_read, .cfg_addr, .cfg_wdata, .cfg_rdata,
      .cfg_rvalid);
   // clock and hang limit
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         results;
      end
   end
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // read one register and compare answer
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      host.rd(a, d, v);
      `CHK("rvalid", 1'b1, v)
      `CHK("rdata", e, d)
   endtask
   task automatic t_reset;
      rchk(8'h05, 8'h00);
      rchk(8'h06, 8'h00);
      rchk(8'h07, 8'h00);
      rchk(8'h08, 8'h00);
      `CHK("dout_oe", 1'b1, data_out_oe)
   endtask
   // largest fraction, lone upper write, then zero
   task automatic t_frac;
      host.set_frac(14'h270F);
      `CHK("frac_upd", 1'b1, pll_fraction_update)
      idle(2);
      `CHK("fraction", 14'h270F, pll_fraction)
      `CHK("frac_upd", 1'b0, pll_fraction_update)
      rchk(8'h05, 8'h9C);
      rchk(8'h06, 8'h3C);
      host.wr(8'h05, 8'h01);
      `CHK("frac_upd", 1'b0, pll_fraction_update)
      idle(2);
      `CHK("fraction", 14'h270F, pll_fraction)
      host.set_frac(14'h0000);
      idle(2);
      `CHK("fraction", 14'h0000, pll_fraction)
   endtask
   // every route code on both lanes, 100 left and -50 right
   task automatic t_route;
      logic signed [15:0] el [4] = '{16'sh0000, 16'sh0064, 16'shFFCE, 16'sh0019};
      logic signed [15:0] er [4] = '{16'sh0000, 16'shFFCE, 16'sh0064, 16'sh0019};
      for (int i = 0; i < 4; i++) begin
         // equal dual rates, bit zero clear
         host.wr(8'h07, {i[0], i[1], i[1], i[1:0], i[1:0], 1'b0});
         idle(2);
         `CHK("ref_rate", i[0], reference_sample_rate)
         `CHK("dual", {i[1], i[1]}, {adc_dual_rate, dac_dual_rate})
         play_in = {16'sh0064, 16'shFFCE};
         play_valid = 1'b1;
         idle(1);
         play_valid = 1'b0;
         `CHK("dac_valid", 1'b1, dac_valid)
         `CHK("dac_out", {el[i], er[i]}, dac_out)
      end
   endtask
   // microphone codes, clock direction, power-down drive, data float
   task automatic t_serial;
      logic [7:0] osr [4] = '{8'h00, 8'h80, 8'h40, 8'h20};
      for (int i = 0; i < 4; i++) begin
         host.wr(8'h08, {5'b10100, i[0], i[1:0]});
         idle(3);
         `CHK("mic_en", (i != 0), mic_enable)
         `CHK("mic_osr", osr[i], mic_oversample)
         `CHK("effect", i[0], effect_3d_enable)
         `CHK("clk_oe", 2'b10, {bit_clock_oe, word_clock_oe})
         `CHK("dout_oe", 1'b0, data_out_oe)
      end
      codec_powered_down = 1'b1;
      idle(3);
      `CHK("bclk_stop", 1'b0, bit_clock_o)
      host.wr(8'h08, 8'hD0);
      idle(3);
      `CHK("clk_run", 3'b111, {bit_clock_o, word_clock_o, word_clock_oe})
      `CHK("dout_oe", 1'b1, data_out_oe)
      codec_powered_down = 1'b0;
      tx_valid = 1'b1;
      tx_bit = 1'b1;
      bit_clock_i = 1'b1;
      word_clock_i = 1'b1;
      host.wr(8'h08, 8'h20);
      idle(3);
      `CHK("dout", 2'b11, {data_out_oe, data_out_o})
      `CHK("follow", 3'b011, {bit_clock_oe, serial_bit_clock, serial_word_clock})
      tx_valid = 1'b0;
      bit_clock_on_pin_two = 1'b1;
      host.wr(8'h08, 8'h80);
      idle(3);
      `CHK("alt_pin", 3'b101, {general_pin_two_oe, bit_clock_oe, general_pin_two_o})
      // the pad must carry the divider clock, not a constant level
      master_bit_clock = 1'b0;
      idle(2);
      `CHK("alt_low", 1'b0, general_pin_two_o)
      master_bit_clock = 1'b1;
      word_clock_on_pin_one = 1'b1;
      host.wr(8'h08, 8'h40);
      idle(3);
      `CHK("alt_word", 3'b101, {general_pin_one_oe, word_clock_oe, general_pin_one_o})
      general_pin_one_i = 1'b1;
      word_clock_i = 1'b0;
      host.wr(8'h08, 8'h00);
      idle(3);
      `CHK("alt_follow", 2'b01, {general_pin_one_oe, serial_word_clock})
   endtask
   // page one hides the registers, unmapped offset reads zero
   task automatic t_page;
      host.wr(8'h07, 8'h18);
      host.wr(8'h00, 8'h01);
      host.wr(8'h07, 8'h7E);
      rchk(8'h00, 8'h01);
      rchk(8'h07, 8'h00);
      rchk(8'h5A, 8'h00);
      host.wr(8'h00, 8'h00);
      rchk(8'h07, 8'h18);
   endtask
   // reset in mid-run clears the registers and the applied fraction again
   task automatic t_midreset;
      host.set_frac(14'h1ABC);
      host.wr(8'h08, 8'hA4);
      idle(2);
      `CHK("fraction", 14'h1ABC, pll_fraction)
      `CHK("dout_oe", 1'b0, data_out_oe)
      reset = 1'b1;
      idle(2);
      reset = 1'b0;
      `CHK("fraction", 14'h0000, pll_fraction)
      t_reset;
   endtask
   // reset then scenarios
   initial begin
      idle(2);
      reset = 1'b0;
      t_reset;
      t_frac;
      t_route;
      t_serial;
      t_page;
      t_midreset;
      results;
   end
endmodule
